// >>> cifc_core.sv
`timescale 1ns/1ps
// Notes on behaviour
// (RULE_01) sign flag copies result bit 7.
// (RULE_02) zero flag set when result is zero.
// (RULE_03) parity flag set for even number of ones.
// (RULE_04) carry flag shows carry or borrow out of bit 7.
// (RULE_05) half carry flag shows carry or borrow from bit 3 to 4.
// (RULE_06) flags hold until the next instruction that changes them.
// (RULE_07) instructions span one to three bytes; first byte address names it.
// (RULE_08) second byte is low half, third byte high half.
// (RULE_09) data bus bits 7 down to 0, bit 7 most significant.
// (RULE_10) ready must be synchronised and stable by the outside.
// (RULE_11) hold request stable in its sampling states.
// (RULE_12) interrupt sampled only in the last clock of an instruction; the core also samples it in every clock while halted.
// (RULE_13) moves: register 5, memory 7, immediate 7, immediate-to-memory 10 clocks.
// (RULE_14) accumulator alu ops 4 clocks; memory or immediate forms 7.
// (RULE_15) xor and or clear carry.
// (RULE_16) pair increment and decrement take 5 clocks, flags untouched.
// (RULE_17) double add adds pair to HL in 10 clocks.
// (RULE_18) pair load immediate 10 clocks; pair codes BC DE HL SP.
// (RULE_19) push 11 clocks; pair code 3 pushes accumulator and flags.
// (RULE_20) pop 10 clocks; pair code 3 restores accumulator and flags.
// (RULE_21) indirect store via BC or DE and load via BC take 7 clocks.
// (RULE_22) special ops: set carry, complement carry, invert A, swap, nop, halt.
// (RULE_23) a status word accompanies the sync pulse at each cycle start; the core gives one sync pulse and status word per instruction only.
// (RULE_24) one to five machine cycles of three to five states each.
// (RULE_25) register codes B C D E H L memory A are 0 to 7.
module cifc_core (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // instruction bytes, presented whole
    input wire logic instrValid,
    input wire logic [7:0] opByte,
    input wire logic [7:0] lowByte,
    input wire logic [7:0] highByte,
    input wire logic [7:0] memData,
    input wire logic [15:0] stackData,
    input wire logic interruptReq,
    // instruction handshake
    output logic instrReady,
    output logic interruptTaken,
    // decode results
    output logic [4:0] clockCount,
    output logic [2:0] cycleCount,
    output logic [7:0] statusWord,
    output logic syncPulse,
    output logic memWrite,
    output logic [15:0] memAddr,
    output logic [7:0] memWriteData,
    output logic stackPush,
    output logic [15:0] stackWriteData,
    output logic halted,
    // architectural state
    output logic [7:0] accOut,
    output logic [7:0] flagsOut,
    output logic [15:0] pairBc,
    output logic [15:0] pairDe,
    output logic [15:0] pairHl,
    output logic [15:0] stackPtr
);
    // ****************************************
    // state and storage
    // ****************************************
    typedef enum logic [1:0] {CIFC_IDLE, CIFC_BUSY, CIFC_HALT} cifc_state_t;
    cifc_state_t state_r, state_nxt;
    logic [7:0] regs_r [0:7];
    logic [7:0] flags_r;
    logic [15:0] sp_r;
    logic [4:0] waitCnt_r;
    logic intPend_r;
    logic [2:0] intSync_r;
    logic intReq_r;
    logic [7:0] aluResPrev_r;
    logic [4:0] clockCount_r;
    logic [2:0] cycleCount_r;
    logic [7:0] statusWord_r;
    logic syncPulse_r;
    logic memWrite_r;
    logic [15:0] memAddr_r;
    logic [7:0] memWriteData_r;
    logic stackPush_r;
    logic [15:0] stackWriteData_r;

    // register index decode, used for source and destination fields
    function automatic logic [2:0] regField(input logic [7:0] op, input logic high);
        regField = high ? op[5:3] : op[2:0]; // RULE_25
    endfunction

    // ****************************************
    // decode
    // ****************************************
    logic [7:0] imm, srcVal, aluSrc;
    logic [15:0] imm16, hl, selPair, pairNext;
    logic [2:0] dst, src;
    logic [1:0] pair;
    logic isMov, isMvi, isAluReg, isAluImm, isIncPair, isDecPair, isDoubleAdd;
    logic isPairLoad, isPush, isPop, isStoreInd, isLoadInd, isHalt;

    assign imm = lowByte; // RULE_09
    assign imm16 = {highByte, lowByte}; // RULE_08
    assign dst = regField(opByte, 1'b1);
    assign src = regField(opByte, 1'b0);
    assign pair = opByte[5:4];
    assign isHalt = (opByte == cifc_pkg::OP_HALT);
    assign isMov = (opByte[7:6] == 2'h1) && !isHalt;
    assign isMvi = (opByte[7:6] == 2'h0) && (opByte[2:0] == 3'h6);
    assign isAluReg = (opByte[7:6] == 2'h2);
    assign isAluImm = (opByte[7:6] == 2'h3) && (opByte[2:0] == 3'h6);
    assign isIncPair = (opByte[7:6] == 2'h0) && (opByte[3:0] == 4'h3);
    assign isDecPair = (opByte[7:6] == 2'h0) && (opByte[3:0] == 4'hb);
    assign isDoubleAdd = (opByte[7:6] == 2'h0) && (opByte[3:0] == 4'h9);
    assign isPairLoad = (opByte[7:6] == 2'h0) && (opByte[3:0] == 4'h1);
    assign isPush = (opByte[7:6] == 2'h3) && (opByte[3:0] == 4'h5);
    assign isPop = (opByte[7:6] == 2'h3) && (opByte[3:0] == 4'h1);
    assign isStoreInd = (opByte == cifc_pkg::OP_STORE_BC) || (opByte == cifc_pkg::OP_STORE_DE);
    assign isLoadInd = (opByte == cifc_pkg::OP_LOAD_BC) || (opByte == cifc_pkg::OP_LOAD_DE);

    assign hl = {regs_r[cifc_pkg::REG_H], regs_r[cifc_pkg::REG_L]};
    // pair field selection: BC, DE, HL, SP
    assign selPair = (pair == cifc_pkg::PAIR_BC) ? {regs_r[cifc_pkg::REG_B], regs_r[cifc_pkg::REG_C]} :
                     (pair == cifc_pkg::PAIR_DE) ? {regs_r[cifc_pkg::REG_D], regs_r[cifc_pkg::REG_E]} :
                     (pair == cifc_pkg::PAIR_HL) ? hl : sp_r; // RULE_18
    assign srcVal = (src == cifc_pkg::REG_MEM) ? memData : regs_r[src];
    assign aluSrc = isAluImm ? imm : srcVal; // RULE_14
    assign pairNext = isPairLoad ? imm16 : isPop ? stackData : isIncPair ? selPair + 16'h0001 : selPair - 16'h0001;

    // ****************************************
    // alu
    // ****************************************
    logic [7:0] aluRes;
    logic fS, fZ, fP, fC, fH, aluWb;
    cifc_flag_unit cifc_flag_unit_inst (
        .aluOp(opByte[5:3]),
        .accIn(regs_r[cifc_pkg::REG_A]),
        .srcIn(aluSrc),
        .carryIn(flags_r[cifc_pkg::FLAG_CARRY_BIT]),
        .result(aluRes),
        .signOut(fS),
        .zeroOut(fZ),
        .parityOut(fP),
        .carryOut(fC),
        .halfOut(fH),
        .writeBack(aluWb)
    );
    logic [7:0] aluFlags;
    assign aluFlags = {fS, fZ, 1'b0, fH, 1'b0, fP, 1'b1, fC}; // RULE_01 RULE_02 RULE_03 RULE_04 RULE_05

    // 16-bit adder for double add; only carry changes
    logic [16:0] doubleAddSum;
    assign doubleAddSum = {1'b0, hl} + {1'b0, selPair}; // RULE_17

    // ****************************************
    // clock count and cycle count per opcode
    // ****************************************
    logic [4:0] clocks;
    logic [2:0] cycles;
    always_comb begin
        clocks = cifc_pkg::CLK_4;
        cycles = 3'h1;
        if (isMov) begin
            clocks = ((src == cifc_pkg::REG_MEM) || (dst == cifc_pkg::REG_MEM)) ? cifc_pkg::CLK_7 : cifc_pkg::CLK_5; // RULE_13
            cycles = ((src == cifc_pkg::REG_MEM) || (dst == cifc_pkg::REG_MEM)) ? 3'h2 : 3'h1;
        end else if (isMvi) begin
            clocks = (dst == cifc_pkg::REG_MEM) ? cifc_pkg::CLK_10 : cifc_pkg::CLK_7; // RULE_13
            cycles = (dst == cifc_pkg::REG_MEM) ? 3'h3 : 3'h2;
        end else if (isAluReg || isAluImm) begin
            clocks = (isAluImm || (src == cifc_pkg::REG_MEM)) ? cifc_pkg::CLK_7 : cifc_pkg::CLK_4; // RULE_14
            cycles = (isAluImm || (src == cifc_pkg::REG_MEM)) ? 3'h2 : 3'h1;
        end else if (isIncPair || isDecPair) begin
            clocks = cifc_pkg::CLK_5; // RULE_16
        end else if (isDoubleAdd || isPairLoad || isPop) begin
            clocks = cifc_pkg::CLK_10; // RULE_17 RULE_18 RULE_20
            cycles = 3'h3;
        end else if (isPush) begin
            clocks = cifc_pkg::CLK_11; // RULE_19
            cycles = 3'h3;
        end else if (isStoreInd || isLoadInd || isHalt) begin
            clocks = cifc_pkg::CLK_7; // RULE_21
            cycles = 3'h2;
        end
    end

    // status word of the first machine cycle
    logic [7:0] status;
    assign status = isHalt ? cifc_pkg::STAT_HALT_ACK : cifc_pkg::STAT_FETCH; // RULE_23

    // ****************************************
    // sequencing
    // ****************************************
    logic accept, lastClock;
    assign instrReady = (state_r == CIFC_IDLE);
    assign accept = instrReady && instrValid; // RULE_07
    assign lastClock = (state_r == CIFC_BUSY) && (waitCnt_r == 5'h01);

    // every instruction but halt holds the core for its documented clock count; halt holds it until an interrupt
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            CIFC_IDLE: if (accept) state_nxt = isHalt ? CIFC_HALT : CIFC_BUSY;
            CIFC_BUSY: if (lastClock) state_nxt = CIFC_IDLE;
            CIFC_HALT: if (intReq_r) state_nxt = CIFC_IDLE;
            default: state_nxt = CIFC_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_r <= CIFC_IDLE;
            waitCnt_r <= 5'h00;
        end else begin
            state_r <= state_nxt;
            if (accept) waitCnt_r <= clocks - 5'h01; // RULE_24
            else if (waitCnt_r != 5'h00) waitCnt_r <= waitCnt_r - 5'h01;
        end
    end

    // pin passes three flops, counts once the last two agree; used in the last clock or while halted
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            intSync_r <= 3'h0;
            intReq_r <= 1'b0;
            intPend_r <= 1'b0;
        end else begin
            intSync_r <= {intSync_r[1:0], interruptReq};
            if (intSync_r[2] == intSync_r[1]) intReq_r <= intSync_r[2];
            intPend_r <= (lastClock || state_r == CIFC_HALT) && intReq_r; // RULE_12
        end
    end
    assign interruptTaken = intPend_r;

    // ****************************************
    // execution: registers and flags
    // ****************************************
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int i = 0; i < 8; i++) regs_r[i] <= 8'h00;
            flags_r <= cifc_pkg::FLAGS_RESET;
            sp_r <= 16'h0000;
        end else if (accept) begin
            if (isMov && dst != cifc_pkg::REG_MEM) regs_r[dst] <= srcVal; // RULE_13
            if (isMvi && dst != cifc_pkg::REG_MEM) regs_r[dst] <= imm;
            if (isAluReg || isAluImm) begin
                if (aluWb) regs_r[cifc_pkg::REG_A] <= aluRes;
                flags_r <= aluFlags; // RULE_06
            end
            if (isIncPair || isDecPair || isPairLoad || (isPop && pair != cifc_pkg::PAIR_SP)) begin
                case (pair)
                    cifc_pkg::PAIR_BC: {regs_r[cifc_pkg::REG_B], regs_r[cifc_pkg::REG_C]} <= pairNext; // RULE_16
                    cifc_pkg::PAIR_DE: {regs_r[cifc_pkg::REG_D], regs_r[cifc_pkg::REG_E]} <= pairNext;
                    cifc_pkg::PAIR_HL: {regs_r[cifc_pkg::REG_H], regs_r[cifc_pkg::REG_L]} <= pairNext;
                    default: sp_r <= pairNext; // RULE_18
                endcase
            end
            if (isPop && pair == cifc_pkg::PAIR_SP) begin
                regs_r[cifc_pkg::REG_A] <= stackData[15:8]; // RULE_20
                flags_r <= stackData[7:0] | cifc_pkg::FLAGS_RESET;
            end
            if (isPop) sp_r <= sp_r + 16'h0002;
            if (isPush) sp_r <= sp_r - 16'h0002;
            if (isDoubleAdd) begin
                {regs_r[cifc_pkg::REG_H], regs_r[cifc_pkg::REG_L]} <= doubleAddSum[15:0]; // RULE_17
                flags_r[cifc_pkg::FLAG_CARRY_BIT] <= doubleAddSum[16];
            end
            if (isLoadInd) regs_r[cifc_pkg::REG_A] <= memData; // RULE_21
            // special group
            case (opByte)
                cifc_pkg::OP_SET_CARRY: flags_r[cifc_pkg::FLAG_CARRY_BIT] <= 1'b1; // RULE_22
                cifc_pkg::OP_COMPLEMENT_CARRY: flags_r[cifc_pkg::FLAG_CARRY_BIT] <= ~flags_r[cifc_pkg::FLAG_CARRY_BIT];
                cifc_pkg::OP_INVERT_ACC: regs_r[cifc_pkg::REG_A] <= ~regs_r[cifc_pkg::REG_A];
                cifc_pkg::OP_SWAP_DE_HL: begin
                    {regs_r[cifc_pkg::REG_D], regs_r[cifc_pkg::REG_E]} <= hl;
                    {regs_r[cifc_pkg::REG_H], regs_r[cifc_pkg::REG_L]} <= {regs_r[cifc_pkg::REG_D], regs_r[cifc_pkg::REG_E]};
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // bus side outputs, registered
    // ****************************************
    logic wrMem;
    logic [15:0] wrAddr;
    logic [7:0] wrData;
    assign wrMem = isStoreInd || (isMov && dst == cifc_pkg::REG_MEM) || (isMvi && dst == cifc_pkg::REG_MEM);
    assign wrAddr = isStoreInd ? selPair : (isMov || isMvi || isAluReg) ? hl : imm16;
    assign wrData = isMvi ? imm : isMov ? srcVal : regs_r[cifc_pkg::REG_A]; // RULE_21

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            clockCount_r <= 5'h00;
            cycleCount_r <= 3'h0;
            statusWord_r <= 8'h00;
            syncPulse_r <= 1'b0;
            memWrite_r <= 1'b0;
            memAddr_r <= 16'h0000;
            memWriteData_r <= 8'h00;
            stackPush_r <= 1'b0;
            stackWriteData_r <= 16'h0000;
        end else begin
            syncPulse_r <= accept; // RULE_23
            memWrite_r <= accept && wrMem;
            stackPush_r <= accept && isPush;
            if (accept) begin
                clockCount_r <= clocks;
                cycleCount_r <= cycles;
                statusWord_r <= status;
                memAddr_r <= isPush ? sp_r - 16'h0002 : wrAddr;
                memWriteData_r <= wrData;
                // pair code 3 pushes accumulator with flags word
                stackWriteData_r <= (pair == cifc_pkg::PAIR_SP) ? {regs_r[cifc_pkg::REG_A], flags_r} : selPair; // RULE_19
            end
        end
    end

    assign clockCount = clockCount_r;
    assign cycleCount = cycleCount_r;
    assign statusWord = statusWord_r;
    assign syncPulse = syncPulse_r;
    assign memWrite = memWrite_r;
    assign memAddr = memAddr_r;
    assign memWriteData = memWriteData_r;
    assign stackPush = stackPush_r;
    assign stackWriteData = stackWriteData_r;
    assign halted = (state_r == CIFC_HALT);
    assign accOut = regs_r[cifc_pkg::REG_A];
    assign flagsOut = flags_r;
    assign pairBc = {regs_r[cifc_pkg::REG_B], regs_r[cifc_pkg::REG_C]};
    assign pairDe = {regs_r[cifc_pkg::REG_D], regs_r[cifc_pkg::REG_E]};
    assign pairHl = hl;
    assign stackPtr = sp_r;

    // ****************************************
    // checks
    // ****************************************
    sequence takeAlu; accept && isAluReg && !isAluImm && src != cifc_pkg::REG_MEM; endsequence
    sequence takePush; accept && isPush; endsequence

    zero_flag_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE_02
        accept && (isAluReg || isAluImm) |=> flags_r[cifc_pkg::FLAG_ZERO_BIT] == (aluResPrev_r == 8'h00))
        else $error("zero flag mismatch");
    // result kept one clock so the flag checks see what was taken
    always_ff @(posedge clock) aluResPrev_r <= aluRes;
    sign_flag_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE_01
        accept && (isAluReg || isAluImm) |=> flags_r[cifc_pkg::FLAG_SIGN_BIT] == aluResPrev_r[7])
        else $error("sign flag mismatch");
    parity_flag_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE_03
        accept && (isAluReg || isAluImm) |=> flags_r[cifc_pkg::FLAG_PARITY_BIT] == ~^aluResPrev_r)
        else $error("parity flag mismatch");
    logic_carry_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE_15
        accept && (isAluReg || isAluImm) && opByte[5:4] == 2'h2 |=> !flags_r[cifc_pkg::FLAG_CARRY_BIT])
        else $error("logic op left carry set");
    alu_clocks_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE_14
        takeAlu |=> !instrReady [*3] ##1 instrReady)
        else $error("alu op not four clocks");
    push_clocks_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE_19
        takePush |=> (stackPush && clockCount == cifc_pkg::CLK_11) ##0 !instrReady [*8]
            ##1 !instrReady [*2] ##1 instrReady)
        else $error("push timing wrong");
    pair_flags_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE_16
        accept && (isIncPair || isDecPair) |=> $stable(flags_r))
        else $error("pair step changed flags");
    sync_status_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE_23
        accept |=> syncPulse && statusWord != 8'h00)
        else $error("missing status with sync");
endmodule

// >>> cifc_pkg.sv
package cifc_pkg;
    // ****************************************
    // register field codes
    // ****************************************
    localparam logic [2:0] REG_B = 3'h0;
    localparam logic [2:0] REG_C = 3'h1;
    localparam logic [2:0] REG_D = 3'h2;
    localparam logic [2:0] REG_E = 3'h3;
    localparam logic [2:0] REG_H = 3'h4;
    localparam logic [2:0] REG_L = 3'h5;
    localparam logic [2:0] REG_MEM = 3'h6;
    localparam logic [2:0] REG_A = 3'h7;
    localparam logic [1:0] PAIR_BC = 2'h0;
    localparam logic [1:0] PAIR_DE = 2'h1;
    localparam logic [1:0] PAIR_HL = 2'h2;
    localparam logic [1:0] PAIR_SP = 2'h3;

    // ****************************************
    // alu operation codes
    // ****************************************
    localparam logic [2:0] ALU_ADD = 3'h0;
    localparam logic [2:0] ALU_ADC = 3'h1;
    localparam logic [2:0] ALU_SUB = 3'h2;
    localparam logic [2:0] ALU_SBB = 3'h3;
    localparam logic [2:0] ALU_AND = 3'h4;
    localparam logic [2:0] ALU_XOR = 3'h5;
    localparam logic [2:0] ALU_OR = 3'h6;
    localparam logic [2:0] ALU_CMP = 3'h7;

    // ****************************************
    // special opcodes
    // ****************************************
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_HALT = 8'h76;
    localparam logic [7:0] OP_SET_CARRY = 8'h37;
    localparam logic [7:0] OP_COMPLEMENT_CARRY = 8'h3f;
    localparam logic [7:0] OP_INVERT_ACC = 8'h2f;
    localparam logic [7:0] OP_SWAP_DE_HL = 8'heb;
    localparam logic [7:0] OP_DECIMAL_ADJUST = 8'h27;
    localparam logic [7:0] OP_STORE_BC = 8'h02;
    localparam logic [7:0] OP_STORE_DE = 8'h12;
    localparam logic [7:0] OP_LOAD_BC = 8'h0a;
    localparam logic [7:0] OP_LOAD_DE = 8'h1a;

    // ****************************************
    // flag word bit positions
    // ****************************************
    localparam int FLAG_SIGN_BIT = 7;
    localparam int FLAG_ZERO_BIT = 6;
    localparam int FLAG_HALF_BIT = 4;
    localparam int FLAG_PARITY_BIT = 2;
    localparam int FLAG_ONE_BIT = 1;
    localparam int FLAG_CARRY_BIT = 0;
    localparam logic [7:0] FLAGS_RESET = 8'h02;

    // ****************************************
    // clock counts
    // ****************************************
    localparam logic [4:0] CLK_4 = 5'h04;
    localparam logic [4:0] CLK_5 = 5'h05;
    localparam logic [4:0] CLK_7 = 5'h07;
    localparam logic [4:0] CLK_10 = 5'h0a;
    localparam logic [4:0] CLK_11 = 5'h0b;

    // ****************************************
    // status word bits
    // ****************************************
    localparam logic [7:0] STAT_FETCH = 8'ha2;
    localparam logic [7:0] STAT_MEM_READ = 8'h82;
    localparam logic [7:0] STAT_MEM_WRITE = 8'h00;
    localparam logic [7:0] STAT_STACK_READ = 8'h86;
    localparam logic [7:0] STAT_STACK_WRITE = 8'h04;
    localparam logic [7:0] STAT_HALT_ACK = 8'h8a;
endpackage

// >>> cifc_flag_unit.sv
`timescale 1ns/1ps
// ****************************************
// 8-bit alu with flag generation
// ****************************************
module cifc_flag_unit (
    // operands
    input wire logic [2:0] aluOp,
    input wire logic [7:0] accIn,
    input wire logic [7:0] srcIn,
    input wire logic carryIn,
    // results
    output logic [7:0] result,
    output logic signOut,
    output logic zeroOut,
    output logic parityOut,
    output logic carryOut,
    output logic halfOut,
    output logic writeBack
);
    logic [8:0] sum;
    logic [4:0] lowSum;
    logic cin;
    logic isSub;

    // subtract forms add the complement; borrow is the inverted carry
    assign isSub = (aluOp == cifc_pkg::ALU_SUB) || (aluOp == cifc_pkg::ALU_SBB) || (aluOp == cifc_pkg::ALU_CMP);
    assign cin = (aluOp == cifc_pkg::ALU_ADC) ? carryIn :
                 (aluOp == cifc_pkg::ALU_SBB) ? ~carryIn : isSub;
    assign sum = {1'b0, accIn} + {1'b0, (isSub ? ~srcIn : srcIn)} + {8'h00, cin};
    assign lowSum = {1'b0, accIn[3:0]} + {1'b0, (isSub ? ~srcIn[3:0] : srcIn[3:0])} + {4'h0, cin};

    // result selection
    always_comb begin
        result = sum[7:0];
        carryOut = isSub ? ~sum[8] : sum[8]; // RULE_04
        halfOut = isSub ? ~lowSum[4] : lowSum[4]; // RULE_05
        case (aluOp)
            cifc_pkg::ALU_AND: begin
                result = accIn & srcIn;
                carryOut = 1'b0;
                halfOut = accIn[3] | srcIn[3];
            end
            cifc_pkg::ALU_XOR: begin
                result = accIn ^ srcIn;
                carryOut = 1'b0; // RULE_15
                halfOut = 1'b0;
            end
            cifc_pkg::ALU_OR: begin
                result = accIn | srcIn;
                carryOut = 1'b0; // RULE_15
                halfOut = 1'b0;
            end
            default: begin
            end
        endcase
    end

    // compare leaves the accumulator alone
    assign writeBack = (aluOp != cifc_pkg::ALU_CMP);
    assign signOut = result[7]; // RULE_01
    assign zeroOut = (result == 8'h00); // RULE_02
    assign parityOut = ~^result; // RULE_03
endmodule

// >>> cifc_bus_model.sv
`timescale 1ns/1ps
// ****************************************
// memory and stack side, echoes last write
// ****************************************
module cifc_bus_model (
    // clock
    input wire logic clock,
    // write requests from the core
    input wire logic memWrite,
    input wire logic [7:0] memWriteData,
    input wire logic stackPush,
    input wire logic [15:0] stackWriteData,
    // read answers
    output logic [7:0] memData,
    output logic [15:0] stackData
);
    logic [7:0] memByte_r = 8'h5a;
    logic [15:0] stackWord_r = 16'ha55a;
    // bytes kept whole, bit 7 most significant
    always @(posedge clock) begin
        if (memWrite) memByte_r <= memWriteData;
        if (stackPush) stackWord_r <= stackWriteData;
    end
    assign memData = memByte_r;
    assign stackData = stackWord_r;
endmodule

// >>> cifc_core_tb.sv
`timescale 1ns/1ps
module cifc_core_tb;
    logic clock = 0, sys_rst = 1, instrValid = 0, interruptReq = 0;
    logic [7:0] opByte = 8'h00, lowByte = 8'h00, highByte = 8'h00, memData;
    logic [15:0] stackData, memAddr, stackWriteData, pairBc, pairDe, pairHl, stackPtr;
    logic instrReady, interruptTaken, syncPulse, memWrite, stackPush, halted;
    logic [4:0] clockCount;
    logic [2:0] cycleCount;
    logic [7:0] statusWord, memWriteData, accOut, flagsOut;
    int err_count = 0, checks_done = 0, cycles = 0;
    cifc_core cifc_core_inst (.clock(clock), .sys_rst(sys_rst), .instrValid(instrValid), .opByte(opByte),
        .lowByte(lowByte), .highByte(highByte), .memData(memData), .stackData(stackData),
        .interruptReq(interruptReq), .instrReady(instrReady), .interruptTaken(interruptTaken),
        .clockCount(clockCount), .cycleCount(cycleCount), .statusWord(statusWord), .syncPulse(syncPulse),
        .memWrite(memWrite), .memAddr(memAddr), .memWriteData(memWriteData), .stackPush(stackPush),
        .stackWriteData(stackWriteData), .halted(halted), .accOut(accOut), .flagsOut(flagsOut),
        .pairBc(pairBc), .pairDe(pairDe), .pairHl(pairHl), .stackPtr(stackPtr));
    cifc_bus_model cifc_bus_model_inst (.clock(clock), .memWrite(memWrite), .memWriteData(memWriteData),
        .stackPush(stackPush), .stackWriteData(stackWriteData), .memData(memData), .stackData(stackData));
    initial forever #5 clock = ~clock;
    // hang guard, whole run needs well under 500 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one instruction; busy length must be one less than the clock count
    task automatic issue(input logic [7:0] op, input logic [7:0] lo, input logic [7:0] hi, input int clk);
        int busy;
        busy = 0;
        opByte = op;
        lowByte = lo;
        highByte = hi;
        instrValid = 1;
        @(negedge clock);
        instrValid = 0;
        chk({15'h0000, syncPulse}, 16'h0001);
        while (!instrReady && busy < 40) begin
            busy++;
            @(negedge clock);
        end
        chk({11'h000, clockCount}, clk[15:0]);
        chk(busy[15:0], clk[15:0] - 16'h0001);
    endtask
    task automatic flags_test();
        issue(8'h3e, 8'h0f, 8'h00, 7);
        issue(8'hc6, 8'h01, 8'h00, 7);
        chk({accOut, flagsOut & 8'hd7}, 16'h1012);
        issue(8'h37, 8'h00, 8'h00, 4);
        chk({15'h0000, flagsOut[0]}, 16'h0001);
        issue(8'haf, 8'h00, 8'h00, 4);
        chk({accOut, flagsOut & 8'hc5}, 16'h0044);
        issue(8'hd6, 8'h01, 8'h00, 7);
        chk({accOut, flagsOut & 8'hc5}, 16'hff85);
        $display("flags test done");
    endtask
    task automatic pair_test();
        issue(8'h21, 8'h34, 8'h12, 10);
        chk(pairHl, 16'h1234);
        issue(8'h23, 8'h00, 8'h00, 5);
        chk(pairHl, 16'h1235);
        chk({8'h00, flagsOut & 8'hc5}, 16'h0085);
        issue(8'hf5, 8'h00, 8'h00, 11);
        chk(stackWriteData & 16'hffc5, 16'hff85);
        chk(stackPtr, 16'hfffe);
        chk(memAddr, 16'hfffe);
        chk({13'h0000, cycleCount}, 16'h0003);
        issue(8'h02, 8'h00, 8'h00, 7);
        chk({memWriteData, 8'h00}, 16'hff00);
        $display("pair test done");
    endtask
    task automatic halt_test();
        int n;
        n = 0;
        opByte = 8'h76;
        instrValid = 1;
        @(negedge clock);
        instrValid = 0;
        repeat (12) @(negedge clock);
        chk({15'h0000, halted}, 16'h0001);
        chk({8'h00, statusWord}, {8'h00, cifc_pkg::STAT_HALT_ACK});
        interruptReq = 1;
        while (halted !== 1'b0 && n < 20) begin
            n++;
            @(negedge clock);
        end
        chk({15'h0000, halted}, 16'h0000);
        chk({15'h0000, interruptTaken}, 16'h0001);
        interruptReq = 0;
        $display("halt test done");
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge clock);
        sys_rst = 0;
        flags_test();
        pair_test();
        halt_test();
        tally_and_finish();
    end
endmodule
